// ===== acss_top.sv
// Scan sequencer for a 16-input converter with channel selection.
// Assumes a converter core with req/done handshake on the same clock.
`timescale 1ns/1ps
// Functional notes
// - Only inputs whose selection bit is one are converted.
// - Low register enables visited from bit 14 down to bit 0.
// - Then high register bits 14 down to 12 are visited.
// - Single-ended results go to the input's own slot, straight binary.
// - Pair A converts input 0 minus 1, stored at 0, two's complement.
// - Pair B converts input 2 minus 3, stored at 2, two's complement.
// - Single-ended bit 14 or 13 set makes pair bit 12 ignored.
// - Pair A is used only when bit 12 set and 14, 13 clear.
// - Single-ended bit 11 or 10 set makes pair bit 9 ignored.
// - Pair B is used only when bit 9 set and 11, 10 clear.
// - Group with all three bits clear is not accessed at all.
// - Low bits 8 down to 0 enable inputs 4 through 12.
// - High bits 14, 13, 12 enable inputs 13, 14, 15.
// - Both selection registers reset to zero.
module acss_top (
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic        reg_wr,
    input  wire logic [6:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    input  wire logic        scan_start,
    output logic             scan_busy,
    output logic             conv_req,
    output logic      [3:0]  conv_pos,
    output logic      [3:0]  conv_neg,
    output logic             conv_diff,
    input  wire logic        conv_done,
    input  wire logic [11:0] conv_code,
    output logic             res_we,
    output logic      [3:0]  res_index,
    output logic      [11:0] res_data,
    output logic             res_twos,
    output logic             scan_end
);
    logic [15:0] sel_low;
    logic [15:0] sel_high;
    logic [17:0] slot_en;
    acss_pkg::acss_state_t state;
    acss_pkg::acss_state_t next_state;
    logic [17:0] pend;
    logic [17:0] next_pend;
    logic [4:0]  slot;
    logic [4:0]  next_slot;
    logic [3:0]  next_conv_pos;
    logic [3:0]  next_conv_neg;
    logic        next_conv_diff;
    logic        next_res_we;
    logic [3:0]  next_res_index;
    logic [11:0] next_res_data;
    logic        next_res_twos;
    logic        next_scan_end;

    acss_regs u_regs (
        .clk_sys   (clk_sys),
        .rst_b     (rst_b),
        .reg_wr    (reg_wr),
        .reg_addr  (reg_addr),
        .reg_wdata (reg_wdata),
        .reg_rdata (reg_rdata),
        .sel_low   (sel_low),
        .sel_high  (sel_high)
    );

    acss_decode u_decode (
        .sel_low  (sel_low),
        .sel_high (sel_high),
        .slot_en  (slot_en)
    );

    // Refuse slot constants that the enable vector cannot hold
    if (acss_pkg::SLOTS != 18 ||
        (2 ** acss_pkg::SLOT_W) < acss_pkg::SLOTS) begin : g_slot_check
        $error("slot constants do not fit the sequencer");
    end

    // Lowest-numbered pending slot is the next in scan order
    function automatic logic [4:0] first_slot(input logic [17:0] v);
        logic [4:0] r;
        r = 5'd0;
        for (int i = 17; i >= 0; i--) begin
            if (v[i]) begin
                r = i[4:0];
            end
        end
        return r;
    endfunction

    // Input number converted in a slot; pair slots use positive input
    function automatic logic [3:0] slot_input(input logic [4:0] s);
        logic [3:0] r;
        case (s)
            5'd0:    r = 4'h0;
            5'd1:    r = 4'h1;
            5'd2:    r = 4'h0;
            5'd3:    r = 4'h2;
            5'd4:    r = 4'h3;
            5'd5:    r = 4'h2;
            default: r = 4'(s - 5'd2);
        endcase
        return r;
    endfunction

    function automatic logic slot_is_pair(input logic [4:0] s);
        return (s == 5'd2) || (s == 5'd5);
    endfunction

    assign scan_busy = (state != acss_pkg::ACSS_IDLE);
    assign conv_req  = (state == acss_pkg::ACSS_REQ);

    // Sequencer next-state
    always_comb begin
        next_state     = state;
        next_pend      = pend;
        next_slot      = slot;
        next_conv_pos  = conv_pos;
        next_conv_neg  = conv_neg;
        next_conv_diff = conv_diff;
        next_res_we    = 1'b0;
        next_res_index = res_index;
        next_res_data  = res_data;
        next_res_twos  = res_twos;
        next_scan_end  = 1'b0;
        case (state)
            acss_pkg::ACSS_IDLE: begin
                // Snapshot enables; a pass visits each once
                if (scan_start && slot_en != 18'h0) begin
                    next_pend  = slot_en;
                    next_slot  = first_slot(slot_en);
                    next_state = acss_pkg::ACSS_REQ;
                    next_conv_pos = slot_input(first_slot(slot_en));
                    next_conv_diff = slot_is_pair(first_slot(slot_en));
                    next_conv_neg = slot_input(first_slot(slot_en))
                                    + 4'h1;
                end
            end
            acss_pkg::ACSS_REQ: begin
                next_state = acss_pkg::ACSS_WAIT;
            end
            acss_pkg::ACSS_WAIT: begin
                if (conv_done) begin
                    next_res_we    = 1'b1;
                    next_res_index = conv_pos;
                    next_res_data  = conv_code;
                    next_res_twos  = conv_diff;
                    next_pend      = pend & ~(18'h1 << slot);
                    if ((pend & ~(18'h1 << slot)) == 18'h0) begin
                        next_state    = acss_pkg::ACSS_IDLE;
                        next_scan_end = 1'b1;
                    end else begin
                        // Jump straight to next set slot
                        next_slot = first_slot(pend & ~(18'h1 << slot));
                        next_conv_pos = slot_input(next_slot);
                        next_conv_neg = slot_input(next_slot) + 4'h1;
                        next_conv_diff = slot_is_pair(next_slot);
                        next_state = acss_pkg::ACSS_REQ;
                    end
                end
            end
            default: begin
                next_state = acss_pkg::ACSS_IDLE;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state     <= acss_pkg::ACSS_IDLE;
            pend      <= 18'h0;
            slot      <= 5'd0;
            conv_pos  <= 4'h0;
            conv_neg  <= 4'h0;
            conv_diff <= 1'b0;
            res_we    <= 1'b0;
            res_index <= 4'h0;
            res_data  <= 12'h000;
            res_twos  <= 1'b0;
            scan_end  <= 1'b0;
        end else begin
            state     <= next_state;
            pend      <= next_pend;
            slot      <= next_slot;
            conv_pos  <= next_conv_pos;
            conv_neg  <= next_conv_neg;
            conv_diff <= next_conv_diff;
            res_we    <= next_res_we;
            res_index <= next_res_index;
            res_data  <= next_res_data;
            res_twos  <= next_res_twos;
            scan_end  <= next_scan_end;
        end
    end

    // A requested slot was enabled at snapshot time
    a_req_enabled: assert property (@(posedge clk_sys) disable iff (!rst_b)
        conv_req |-> pend[slot])
        else $error("conversion requested for unselected slot");

    // Pair A uses inputs 0 and 1 in differential mode
    a_pair_a_inputs: assert property (@(posedge clk_sys) disable iff (!rst_b)
        conv_req && slot == 5'd2 |->
            conv_diff && conv_pos == 4'h0 && conv_neg == 4'h1)
        else $error("pair A inputs wrong");

    // Pair B uses inputs 2 and 3 in differential mode
    a_pair_b_inputs: assert property (@(posedge clk_sys) disable iff (!rst_b)
        conv_req && slot == 5'd5 |->
            conv_diff && conv_pos == 4'h2 && conv_neg == 4'h3)
        else $error("pair B inputs wrong");

    // Pair A never converted while a group A single bit is set
    a_pair_a_block: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (sel_low[14] | sel_low[13]) |-> !slot_en[2])
        else $error("pair A enabled alongside single inputs");

    a_pair_a_only: assert property (@(posedge clk_sys) disable iff (!rst_b)
        slot_en[2] == (sel_low[12] && !sel_low[14] && !sel_low[13]))
        else $error("pair A enable decode wrong");

    a_pair_b_block: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (sel_low[11] | sel_low[10]) |-> !slot_en[5])
        else $error("pair B enabled alongside single inputs");

    a_pair_b_only: assert property (@(posedge clk_sys) disable iff (!rst_b)
        slot_en[5] == (sel_low[9] && !sel_low[11] && !sel_low[10]))
        else $error("pair B enable decode wrong");

    // Empty selection starts nothing
    a_empty_idle: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (state == acss_pkg::ACSS_IDLE && scan_start && slot_en == 18'h0)
            |=> state == acss_pkg::ACSS_IDLE)
        else $error("scan started with nothing selected");

    // Order: the next slot is always beyond the finished one
    sequence s_done_more;
        state == acss_pkg::ACSS_WAIT && conv_done && next_pend != 18'h0;
    endsequence
    a_scan_order: assert property (@(posedge clk_sys) disable iff (!rst_b)
        s_done_more |=> conv_req && slot > $past(slot))
        else $error("scan order not ascending");

    // Result written with format matching mode
    a_result_fmt: assert property (@(posedge clk_sys) disable iff (!rst_b)
        state == acss_pkg::ACSS_WAIT && conv_done |=>
            res_we && res_twos == $past(conv_diff)
            && res_index == $past(conv_pos))
        else $error("result index or format wrong");

    // Request goes straight to the wait state with no idle cycle
    a_no_gap: assert property (@(posedge clk_sys) disable iff (!rst_b)
        conv_req |=> state == acss_pkg::ACSS_WAIT)
        else $error("sequencer stalled after request");

    // Reset-free view: the low register holds no reserved bit 15
    a_sel_reserved: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !sel_low[15])
        else $error("reserved selection bit set");

    a_high_map: assert property (@(posedge clk_sys) disable iff (!rst_b)
        conv_req && slot >= 5'd15 |-> conv_pos == 4'(slot - 5'd2))
        else $error("high register slot mapped wrong");

    a_low_map: assert property (@(posedge clk_sys) disable iff (!rst_b)
        conv_req && slot >= 5'd6 && slot <= 5'd14
            |-> conv_pos == 4'(slot - 5'd2) && !conv_diff)
        else $error("low register slot mapped wrong");

    // Scan start: snapshot taken and first request follows at once
    sequence s_start_taken;
        state == acss_pkg::ACSS_IDLE && scan_start && slot_en != 18'h0;
    endsequence
    a_start_snap: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        s_start_taken |=> conv_req && pend == $past(slot_en))
        else $error("scan start did not snapshot the selection");

    // Last result ends the pass in the cycle of its write
    sequence s_done_last;
        state == acss_pkg::ACSS_WAIT && conv_done && next_pend == 18'h0;
    endsequence
    a_pass_end: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        s_done_last |=> scan_end && res_we && !scan_busy)
        else $error("pass did not end after last result");

    // A finished slot is never visited again in the same pass
    a_visit_once: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        state == acss_pkg::ACSS_WAIT && conv_done
            |=> !pend[$past(slot)])
        else $error("finished slot still pending");

    // Single-ended slots convert without a negative input
    a_single_mode: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        conv_req && !slot_is_pair(slot) |-> !conv_diff)
        else $error("single-ended slot requested as differential");

    // Differential request pairs the positive input with the next one
    a_pair_neg: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        conv_req && conv_diff |-> conv_neg == conv_pos + 4'h1)
        else $error("differential negative input wrong");

    // Decode keeps scan order: low bit 14 first, high bits last
    a_slot_decode: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        slot_en[0] == sel_low[14] && slot_en[6] == sel_low[8]
            && slot_en[14] == sel_low[0]
            && slot_en[17:15] == {sel_high[12], sel_high[13], sel_high[14]})
        else $error("slot decode out of scan order");
endmodule // acss_top

// ===== acss_pkg.sv
// Constants for the ADC channel scan selection block.
// Assumes a 7-bit register address and 16-bit register data.
package acss_pkg;
    localparam logic [6:0]  ADDR_SEL_LOW     = 7'h50;
    localparam logic [6:0]  ADDR_SEL_HIGH    = 7'h51;
    localparam logic [15:0] SEL_LOW_RESET    = 16'h0000;
    localparam logic [15:0] SEL_HIGH_RESET   = 16'h0000;
    // Writable bits; bit 15 of the low register reads zero
    localparam logic [15:0] SEL_LOW_MASK     = 16'h7fff;
    localparam logic [15:0] SEL_HIGH_MASK    = 16'hffff;
    localparam int          POS_SE0          = 14;
    localparam int          POS_SE1          = 13;
    localparam int          POS_PAIR_A       = 12;
    localparam int          POS_SE2          = 11;
    localparam int          POS_SE3          = 10;
    localparam int          POS_PAIR_B       = 9;
    localparam int          SLOTS            = 18;
    localparam int          SLOT_W           = 5;
    typedef enum logic [1:0] {
        ACSS_IDLE = 2'b00,
        ACSS_REQ  = 2'b01,
        ACSS_WAIT = 2'b10
    } acss_state_t;
endpackage

// ===== acss_regs.sv
// Holds the two channel selection registers.
// Assumes a same-clock register port with one-cycle write strobe.
`timescale 1ns/1ps
module acss_regs (
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic        reg_wr,
    input  wire logic [6:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    output logic      [15:0] sel_low,
    output logic      [15:0] sel_high
);
    logic [15:0] next_sel_low;
    logic [15:0] next_sel_high;

    // Next values on a decoded write
    always_comb begin
        next_sel_low  = sel_low;
        next_sel_high = sel_high;
        if (reg_wr && reg_addr == acss_pkg::ADDR_SEL_LOW) begin
            next_sel_low = reg_wdata & acss_pkg::SEL_LOW_MASK;
        end
        if (reg_wr && reg_addr == acss_pkg::ADDR_SEL_HIGH) begin
            next_sel_high = reg_wdata & acss_pkg::SEL_HIGH_MASK;
        end
    end

    // Both registers clear at reset, nothing selected
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sel_low  <= acss_pkg::SEL_LOW_RESET;
            sel_high <= acss_pkg::SEL_HIGH_RESET;
        end else begin
            sel_low  <= next_sel_low;
            sel_high <= next_sel_high;
        end
    end

    // Read mux, unmapped reads zero
    always_comb begin
        case (reg_addr)
            acss_pkg::ADDR_SEL_LOW:  reg_rdata = sel_low;
            acss_pkg::ADDR_SEL_HIGH: reg_rdata = sel_high;
            default:                 reg_rdata = 16'h0000;
        endcase
    end
endmodule // acss_regs

// ===== acss_decode.sv
// Turns the selection registers into an 18-slot enable vector.
// Slot order is scan order; purely combinational.
`timescale 1ns/1ps
module acss_decode (
    input  wire logic [15:0] sel_low,
    input  wire logic [15:0] sel_high,
    output logic      [17:0] slot_en
);
    logic grp_a_se;
    logic grp_b_se;

    // Any single-ended bit of a group wins over its pair bit
    assign grp_a_se = sel_low[acss_pkg::POS_SE0] | sel_low[acss_pkg::POS_SE1];
    assign grp_b_se = sel_low[acss_pkg::POS_SE2] | sel_low[acss_pkg::POS_SE3];

    // Slot k maps to low bit 14-k, slots 15..17 to high bits 14..12
    always_comb begin
        slot_en = 18'h0;
        for (int k = 0; k <= 14; k++) begin
            slot_en[k] = sel_low[14 - k];
        end
        slot_en[14 - acss_pkg::POS_PAIR_A] =
            sel_low[acss_pkg::POS_PAIR_A] & ~grp_a_se;
        slot_en[14 - acss_pkg::POS_PAIR_B] =
            sel_low[acss_pkg::POS_PAIR_B] & ~grp_b_se;
        slot_en[15] = sel_high[14];
        slot_en[16] = sel_high[13];
        slot_en[17] = sel_high[12];
    end
endmodule // acss_decode

// ===== acss_top_bench.sv
// Self-checking bench for the channel scan sequencer top.
// Assumes acss_pkg is compiled first; the bench acts as converter and host.
`timescale 1ns/1ps
module acss_top_bench;
    logic        clk_sys;
    logic        rst_b;
    logic        reg_wr;
    logic [6:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata;
    logic        scan_start;
    logic        scan_busy;
    logic        conv_req;
    logic [3:0]  conv_pos;
    logic [3:0]  conv_neg;
    logic        conv_diff;
    logic        conv_done;
    logic [11:0] conv_code;
    logic        res_we;
    logic [3:0]  res_index;
    logic [11:0] res_data;
    logic        res_twos;
    logic        scan_end;
    int          n_mismatch;
    int          n_tests;
    int          cycles;
    logic [4:0]  exp_q [$];
    logic [15:0] lo_tab [9] = '{16'h7000, 16'h1000, 16'h0200, 16'h0e00,
        16'h2400, 16'h01ff, 16'h5555, 16'h0000, 16'h0000};
    logic [15:0] hi_tab [9] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h7000, 16'h2000, 16'h0000, 16'h0800};

    acss_top dut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .scan_start(scan_start), .scan_busy(scan_busy),
        .conv_req(conv_req), .conv_pos(conv_pos), .conv_neg(conv_neg),
        .conv_diff(conv_diff), .conv_done(conv_done),
        .conv_code(conv_code), .res_we(res_we), .res_index(res_index),
        .res_data(res_data), .res_twos(res_twos), .scan_end(scan_end));

    // Clock at 100 MHz
    always #5 clk_sys = ~clk_sys;

    // Hang guard
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_mismatch = n_mismatch + 1;
            final_report();
        end
    end

    // Compares one value and counts it
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("mismatch %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        if (n_mismatch == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // One-cycle write strobe, launched at the falling edge
    task automatic reg_write(input logic [6:0] a, input logic [15:0] d);
        @(negedge clk_sys);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk_sys);
        reg_wr = 1'b0;
    endtask

    // Read data is combinational from the address; set at falling edge
    task automatic reg_read(input logic [6:0] a, input logic [15:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        #1;
        check(reg_rdata, d);
    endtask

    // Expected scan order: {diff, input} per conversion
    task automatic build(input logic [15:0] lo, input logic [15:0] hi);
        exp_q.delete();
        if (lo[14]) exp_q.push_back(5'h00);
        if (lo[13]) exp_q.push_back(5'h01);
        if (lo[12] && !lo[14] && !lo[13]) exp_q.push_back(5'h10);
        if (lo[11]) exp_q.push_back(5'h02);
        if (lo[10]) exp_q.push_back(5'h03);
        if (lo[9] && !lo[11] && !lo[10]) exp_q.push_back(5'h12);
        for (int k = 8; k >= 0; k--)
            if (lo[k]) exp_q.push_back({1'b0, 4'(12 - k)});
        for (int k = 14; k >= 12; k--)
            if (hi[k]) exp_q.push_back({1'b0, 4'(27 - k)});
    endtask

    // Runs one pass; mid also writes and raises scan_start during the pass
    task automatic scan(input logic [15:0] lo, input logic [15:0] hi,
                        input bit mid);
        logic [11:0] code;
        reg_write(acss_pkg::ADDR_SEL_LOW, lo);
        reg_write(acss_pkg::ADDR_SEL_HIGH, hi);
        build(lo, hi);
        scan_start = 1'b1;
        @(negedge clk_sys);
        scan_start = 1'b0;
        if (exp_q.size() == 0) begin
            repeat (3) begin
                check({15'h0000, scan_busy}, 16'h0000);
                check({15'h0000, conv_req}, 16'h0000);
                @(negedge clk_sys);
            end
            return;
        end
        check({15'h0000, scan_busy}, 16'h0001);
        for (int i = 0; i < exp_q.size(); i++) begin
            code = {exp_q[i][3:0], 4'h9, 4'(i)};
            check({15'h0000, conv_req}, 16'h0001);
            check({12'h000, conv_pos}, {12'h000, exp_q[i][3:0]});
            check({15'h0000, conv_diff}, {15'h0000, exp_q[i][4]});
            if (exp_q[i][4])
                check({12'h000, conv_neg},
                      {12'h000, exp_q[i][3:0] + 4'h1});
            if (mid && i == 0) begin
                reg_wr = 1'b1;
                reg_addr = acss_pkg::ADDR_SEL_LOW;
                reg_wdata = 16'h0000;
            end
            for (int j = 0; j < ((i % 2) ? 3 : 1); j++) begin
                @(negedge clk_sys);
                reg_wr = 1'b0;
                scan_start = (mid && i == 1 && j == 0);
                check({15'h0000, conv_req}, 16'h0000);
            end
            conv_done = 1'b1;
            conv_code = code;
            @(negedge clk_sys);
            conv_done = 1'b0;
            check({15'h0000, res_we}, 16'h0001);
            check({12'h000, res_index}, {12'h000, exp_q[i][3:0]});
            check({4'h0, res_data}, {4'h0, code});
            check({15'h0000, res_twos}, {15'h0000, exp_q[i][4]});
        end
        check({15'h0000, conv_req}, 16'h0000);
        check({15'h0000, scan_end}, 16'h0001);
        check({15'h0000, scan_busy}, 16'h0000);
        @(negedge clk_sys);
        check({15'h0000, scan_end}, 16'h0000);
        if (mid)
            reg_read(acss_pkg::ADDR_SEL_LOW, 16'h0000);
    endtask

    // Main sequence
    initial begin
        clk_sys = 1'b0;
        rst_b = 1'b0;
        reg_wr = 1'b0;
        reg_addr = 7'h00;
        reg_wdata = 16'h0000;
        scan_start = 1'b0;
        conv_done = 1'b0;
        conv_code = 12'h000;
        n_mismatch = 0;
        n_tests = 0;
        cycles = 0;
        repeat (5) @(negedge clk_sys);
        reg_read(acss_pkg::ADDR_SEL_LOW, acss_pkg::SEL_LOW_RESET);
        reg_read(acss_pkg::ADDR_SEL_HIGH, acss_pkg::SEL_HIGH_RESET);
        @(negedge clk_sys);
        rst_b = 1'b1;
        reg_read(acss_pkg::ADDR_SEL_LOW, 16'h0000);
        reg_read(acss_pkg::ADDR_SEL_HIGH, 16'h0000);
        reg_write(acss_pkg::ADDR_SEL_LOW, 16'hffff);
        reg_write(acss_pkg::ADDR_SEL_HIGH, 16'hffff);
        reg_write(7'h52, 16'h1234);
        reg_read(acss_pkg::ADDR_SEL_LOW, 16'h7fff);
        reg_read(acss_pkg::ADDR_SEL_HIGH, 16'hffff);
        reg_read(7'h52, 16'h0000);
        for (int c = 0; c < 9; c++)
            scan(lo_tab[c], hi_tab[c], c == 6);
        // Reset in mid-run clears both registers, then a pass still runs
        reg_write(acss_pkg::ADDR_SEL_LOW, 16'h0123);
        @(negedge clk_sys);
        rst_b = 1'b0;
        reg_read(acss_pkg::ADDR_SEL_LOW, 16'h0000);
        reg_read(acss_pkg::ADDR_SEL_HIGH, 16'h0000);
        check({15'h0000, scan_busy}, 16'h0000);
        @(negedge clk_sys);
        rst_b = 1'b1;
        scan(16'h0100, 16'h0000, 1'b0);
        final_report();
    end
endmodule // acss_top_bench
